/* File: verilog/adcts_consts.vh */
/*
 * Constants for the converter timing and setup block: register indices,
 * field positions, reset values, encodings and stage codes.
 * Assumes it is included by bare name into the design files.
 */
`ifndef ADCTS_CONSTS_VH
`define ADCTS_CONSTS_VH

// Register indices as printed; the byte address is four times the index.
`define ADCTS_IDX_FILTER_OUT     10'h094
`define ADCTS_IDX_TRIG_TALLY     10'h099
`define ADCTS_IDX_REPEAT_TGT     10'h09a
`define ADCTS_IDX_POS_CHANNEL    10'h09f
`define ADCTS_IDX_SAMPLING_LEN   10'h10c
`define ADCTS_IDX_SAMPLE_LOAD    10'h10e
`define ADCTS_IDX_PRECHARGE_LEN  10'h10f
`define ADCTS_IDX_REF_SELECT     10'h116
`define ADCTS_IDX_CLK_DIVIDER    10'h118
`define ADCTS_IDX_CONTROL        10'h120
`define ADCTS_IDX_STATUS         10'h121

// Field widths.
`define ADCTS_DIV_W              6
`define ADCTS_CH_W               6
`define ADCTS_LEN_W              13
`define ADCTS_LOAD_W             5
`define ADCTS_MODE_W             3
`define ADCTS_STAGE_W            3

// Field positions inside the reference select register.
`define ADCTS_REF_LOWER_BIT      4
`define ADCTS_REF_UPPER_HI       1
`define ADCTS_REF_UPPER_LO       0

// Control register: start strobe at bit 0, mode field at bits 6:4.
`define ADCTS_CTL_START_BIT      0
`define ADCTS_CTL_MODE_HI        6
`define ADCTS_CTL_MODE_LO        4

// Reset values.
`define ADCTS_RST_BYTE           8'h00
`define ADCTS_RST_LEN            13'h0000
`define ADCTS_RST_MODE           3'h0

// Upper reference encodings.
`define ADCTS_UREF_SUPPLY        2'h0
`define ADCTS_UREF_RESERVED      2'h1
`define ADCTS_UREF_EXTERNAL      2'h2
`define ADCTS_UREF_FIXED         2'h3

// Computation modes.
`define ADCTS_MODE_BASIC         3'h0
`define ADCTS_MODE_ACCUM         3'h1
`define ADCTS_MODE_AVERAGE       3'h2
`define ADCTS_MODE_BURST         3'h3
`define ADCTS_MODE_LOWPASS       3'h4

// Stage codes reported in status.
`define ADCTS_STG_IDLE           3'h0
`define ADCTS_STG_PRECHARGE      3'h1
`define ADCTS_STG_ACQUIRE        3'h2
`define ADCTS_STG_CONVERT        3'h3

// Acquisition length used when precharge is set and acquisition is zero.
`define ADCTS_ACQ_LONG           14'h2000
// Conversion stage length in conversion clocks.
`define ADCTS_CONV_CLOCKS        14'h000e

`endif

/* File: verilog/adcts_clk_div.v */
/*
 * Conversion clock tick generator: one pulse every 2*(div+1) system clocks.
 * Assumes a synchronous active-high reset and a divider setting that may
 * change at any time; a change takes effect on the count already running.
 */
`timescale 1ns/100ps
`include "adcts_consts.vh"

module adcts_clk_div #(
	parameter DIV_W = `ADCTS_DIV_W
) (
	input  wire             clk_sys,
	input  wire             srst,
	input  wire [DIV_W-1:0] divSel,
	output reg              tick_ff
);

	reg  [DIV_W:0] cnt_ff;
	wire [DIV_W:0] lastCnt;

	// Terminal count is 2*(div+1)-1, so a setting of zero ticks every other clock.
	assign lastCnt = {divSel, 1'b1};

	// The count is compared with >= so a lowered setting never strands it.
	always @(posedge clk_sys) begin
		if (srst) begin
			cnt_ff  <= {(DIV_W+1){1'b0}};
			tick_ff <= 1'b0;
		end else if (cnt_ff >= lastCnt) begin
			cnt_ff  <= {(DIV_W+1){1'b0}};
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + {{DIV_W{1'b0}}, 1'b1};
			tick_ff <= 1'b0;
		end
	end

endmodule

/* File: verilog/adcts_top.v */
/*
 * Converter timing and setup block with a classic Wishbone slave.
 * Holds the divider, reference, channel, precharge, acquisition, sample load,
 * repeat target and trigger tally registers, and sequences the stages of
 * one conversion in conversion-clock ticks.
 * Assumes a single 200 MHz clock, synchronous active-high reset, and an
 * analogue front end that takes the decoded selects below as levels.
 */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`include "adcts_consts.vh"

module adcts_top #(
	parameter DIV_W  = `ADCTS_DIV_W,
	parameter CH_W   = `ADCTS_CH_W,
	parameter LEN_W  = `ADCTS_LEN_W,
	parameter LOAD_W = `ADCTS_LOAD_W
) (
	input  wire              clk_sys,
	input  wire              srst,
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [11:0]       wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o,
	input  wire              convTrigger,
	input  wire [15:0]       filterValue,
	output reg               lowerRefExternal,
	output reg               upperRefSupply,
	output reg               upperRefExternal,
	output reg               upperRefFixed,
	output reg  [CH_W-1:0]   channelSelect,
	output reg  [LOAD_W-1:0] sampleLoadPf,
	output reg               prechargeActive,
	output reg               acquireActive,
	output reg               convertActive,
	output reg               thresholdCheck
);

	localparam ST_IDLE = 2'h0;
	localparam ST_PRE  = 2'h1;
	localparam ST_ACQ  = 2'h2;
	localparam ST_CONV = 2'h3;

	// Software-visible configuration.
	reg  [DIV_W-1:0]  divider_ff;
	reg               lowerRef_ff;
	reg  [1:0]        upperRef_ff;
	reg  [CH_W-1:0]   channel_ff;
	reg  [LEN_W-1:0]  preLen_ff;
	reg  [LEN_W-1:0]  acqLen_ff;
	reg  [LOAD_W-1:0] sampleLoad_ff;
	reg  [7:0]        repeatTgt_ff;
	reg  [7:0]        tally_ff;
	reg  [2:0]        mode_ff;

	// Sequencer state.
	reg  [1:0]        state_ff;
	reg  [1:0]        nxt_state;
	reg  [13:0]       stageCnt_ff;
	reg  [13:0]       nxt_stageCnt;
	reg               pending_ff;
	reg  [2:0]        stageCode;

	wire              convTick;
	wire              access;
	wire              wrStb;
	wire [9:0]        regIdx;
	wire              tallyModeOn;
	wire              startWr;
	wire [13:0]       acqCount;

	adcts_clk_div #(
		.DIV_W (DIV_W)
	) u_div (
		.clk_sys (clk_sys),
		.srst    (srst),
		.divSel  (divider_ff),
		.tick_ff (convTick)
	);

	// Word index from the byte address; the low two bits select nothing.
	assign regIdx  = wb_adr_i[11:2];
	assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrStb   = access & wb_we_i;
	assign startWr = wrStb & (regIdx == `ADCTS_IDX_CONTROL) & wb_sel_i[0] & wb_dat_i[`ADCTS_CTL_START_BIT];

	// Only the three averaging-style modes use the repeat machinery.
	assign tallyModeOn = (mode_ff == `ADCTS_MODE_LOWPASS) | (mode_ff == `ADCTS_MODE_BURST) |
		(mode_ff == `ADCTS_MODE_AVERAGE);

	// Zero acquisition after a real precharge stretches to the long figure instead of vanishing.
	assign acqCount = ((acqLen_ff == `ADCTS_RST_LEN) && (preLen_ff != `ADCTS_RST_LEN)) ?
		`ADCTS_ACQ_LONG : {1'b0, acqLen_ff};

	// Configuration writes; each register only honours the byte lanes it owns.
	always @(posedge clk_sys) begin
		if (srst) begin
			divider_ff    <= {DIV_W{1'b0}};
			lowerRef_ff   <= 1'b0;
			upperRef_ff   <= `ADCTS_UREF_SUPPLY;
			channel_ff    <= {CH_W{1'b0}};
			preLen_ff     <= `ADCTS_RST_LEN;
			acqLen_ff     <= `ADCTS_RST_LEN;
			sampleLoad_ff <= {LOAD_W{1'b0}};
			repeatTgt_ff  <= `ADCTS_RST_BYTE;
			mode_ff       <= `ADCTS_RST_MODE;
		end else if (wrStb) begin
			case (regIdx)
				`ADCTS_IDX_CLK_DIVIDER: begin
					if (wb_sel_i[0]) divider_ff <= wb_dat_i[DIV_W-1:0];
				end
				`ADCTS_IDX_REF_SELECT: begin
					if (wb_sel_i[0]) begin
						lowerRef_ff <= wb_dat_i[`ADCTS_REF_LOWER_BIT];
						upperRef_ff <= wb_dat_i[`ADCTS_REF_UPPER_HI:`ADCTS_REF_UPPER_LO];
					end
				end
				`ADCTS_IDX_POS_CHANNEL: begin
					if (wb_sel_i[0]) channel_ff <= wb_dat_i[CH_W-1:0];
				end
				`ADCTS_IDX_PRECHARGE_LEN: begin
					if (wb_sel_i[0]) preLen_ff[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) preLen_ff[LEN_W-1:8] <= wb_dat_i[LEN_W-1:8];
				end
				`ADCTS_IDX_SAMPLING_LEN: begin
					if (wb_sel_i[0]) acqLen_ff[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) acqLen_ff[LEN_W-1:8] <= wb_dat_i[LEN_W-1:8];
				end
				`ADCTS_IDX_SAMPLE_LOAD: begin
					if (wb_sel_i[0]) sampleLoad_ff <= wb_dat_i[LOAD_W-1:0];
				end
				`ADCTS_IDX_REPEAT_TGT: begin
					if (wb_sel_i[0]) repeatTgt_ff <= wb_dat_i[7:0];
				end
				`ADCTS_IDX_CONTROL: begin
					if (wb_sel_i[0]) mode_ff <= wb_dat_i[`ADCTS_CTL_MODE_HI:`ADCTS_CTL_MODE_LO];
				end
				default: begin
				end
			endcase
		end
	end

	// The tally has no reset on purpose so that it survives the block reset.
	// A trigger in the same cycle as a software write wins, so no event is lost.
	always @(posedge clk_sys) begin
		if (convTrigger && tallyModeOn) begin
			if (tally_ff >= repeatTgt_ff)
				tally_ff <= 8'h01;
			else
				tally_ff <= tally_ff + 8'h01;
		end else if (wrStb && (regIdx == `ADCTS_IDX_TRIG_TALLY) && wb_sel_i[0]) begin
			tally_ff <= wb_dat_i[7:0];
		end
	end

	// Threshold check pulse when the tally reaches the target.
	always @(posedge clk_sys) begin
		if (srst)
			thresholdCheck <= 1'b0;
		else
			thresholdCheck <= convTrigger & tallyModeOn &
				((tally_ff >= repeatTgt_ff) ? (repeatTgt_ff == 8'h01) :
				(tally_ff + 8'h01 == repeatTgt_ff));
	end

	// A start request is latched until the sequencer is idle to take it.
	always @(posedge clk_sys) begin
		if (srst)
			pending_ff <= 1'b0;
		else if (convTrigger || startWr)
			pending_ff <= 1'b1;
		else if (state_ff == ST_IDLE)
			pending_ff <= 1'b0;
	end

	// Stage sequencer: counts whole conversion clocks, skipping zero-length stages.
	always @* begin
		nxt_state    = state_ff;
		nxt_stageCnt = stageCnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (pending_ff) begin
					if (preLen_ff != `ADCTS_RST_LEN) begin
						nxt_state    = ST_PRE;
						nxt_stageCnt = {1'b0, preLen_ff};
					end else if (acqCount != 14'h0000) begin
						nxt_state    = ST_ACQ;
						nxt_stageCnt = acqCount;
					end else begin
						nxt_state    = ST_CONV;
						nxt_stageCnt = `ADCTS_CONV_CLOCKS;
					end
				end
			end
			ST_PRE: begin
				if (convTick) begin
					if (stageCnt_ff == 14'h0001) begin
						nxt_state    = ST_ACQ;
						nxt_stageCnt = acqCount;
					end else begin
						nxt_stageCnt = stageCnt_ff - 14'h0001;
					end
				end
			end
			ST_ACQ: begin
				if (convTick) begin
					if (stageCnt_ff == 14'h0001) begin
						nxt_state    = ST_CONV;
						nxt_stageCnt = `ADCTS_CONV_CLOCKS;
					end else begin
						nxt_stageCnt = stageCnt_ff - 14'h0001;
					end
				end
			end
			ST_CONV: begin
				if (convTick) begin
					if (stageCnt_ff == 14'h0001)
						nxt_state = ST_IDLE;
					else
						nxt_stageCnt = stageCnt_ff - 14'h0001;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			state_ff    <= ST_IDLE;
			stageCnt_ff <= 14'h0000;
		end else begin
			state_ff    <= nxt_state;
			stageCnt_ff <= nxt_stageCnt;
		end
	end

	// Stage code for status, one pass only.
	always @* begin
		case (state_ff)
			ST_PRE:  stageCode = `ADCTS_STG_PRECHARGE;
			ST_ACQ:  stageCode = `ADCTS_STG_ACQUIRE;
			ST_CONV: stageCode = `ADCTS_STG_CONVERT;
			default: stageCode = `ADCTS_STG_IDLE;
		endcase
	end

	// Registered analogue selects so the front end sees glitch-free levels.
	always @(posedge clk_sys) begin
		if (srst) begin
			lowerRefExternal <= 1'b0;
			upperRefSupply   <= 1'b1;
			upperRefExternal <= 1'b0;
			upperRefFixed    <= 1'b0;
			channelSelect    <= {CH_W{1'b0}};
			sampleLoadPf     <= {LOAD_W{1'b0}};
			prechargeActive  <= 1'b0;
			acquireActive    <= 1'b0;
			convertActive    <= 1'b0;
		end else begin
			lowerRefExternal <= lowerRef_ff;
			upperRefSupply   <= (upperRef_ff == `ADCTS_UREF_SUPPLY);
			upperRefExternal <= (upperRef_ff == `ADCTS_UREF_EXTERNAL);
			upperRefFixed    <= (upperRef_ff == `ADCTS_UREF_FIXED);
			channelSelect    <= channel_ff;
			sampleLoadPf     <= sampleLoad_ff;
			prechargeActive  <= (nxt_state == ST_PRE);
			acquireActive    <= (nxt_state == ST_ACQ);
			convertActive    <= (nxt_state == ST_CONV);
		end
	end

	// Wishbone answer: one wait cycle, ack for one cycle, unmapped reads give zero.
	always @(posedge clk_sys) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= 32'h00000000;
			if (access && !wb_we_i) begin
				case (regIdx)
					`ADCTS_IDX_FILTER_OUT:    wb_dat_o <= {16'h0000, filterValue};
					`ADCTS_IDX_TRIG_TALLY:    wb_dat_o <= {24'h000000, tally_ff};
					`ADCTS_IDX_REPEAT_TGT:    wb_dat_o <= {24'h000000, repeatTgt_ff};
					`ADCTS_IDX_POS_CHANNEL:   wb_dat_o <= {{(32-CH_W){1'b0}}, channel_ff};
					`ADCTS_IDX_SAMPLING_LEN:  wb_dat_o <= {{(32-LEN_W){1'b0}}, acqLen_ff};
					`ADCTS_IDX_SAMPLE_LOAD:   wb_dat_o <= {{(32-LOAD_W){1'b0}}, sampleLoad_ff};
					`ADCTS_IDX_PRECHARGE_LEN: wb_dat_o <= {{(32-LEN_W){1'b0}}, preLen_ff};
					`ADCTS_IDX_REF_SELECT:    wb_dat_o <= {27'h0000000, lowerRef_ff, 2'h0, upperRef_ff};
					`ADCTS_IDX_CLK_DIVIDER:   wb_dat_o <= {{(32-DIV_W){1'b0}}, divider_ff};
					`ADCTS_IDX_CONTROL:       wb_dat_o <= {25'h0000000, mode_ff, 4'h0};
					`ADCTS_IDX_STATUS:        wb_dat_o <= {29'h00000000, stageCode};
					default:                  wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

/* File: verif/adcts_front_model.sv */
/* Analogue front-end stand-in: turns a bench request into a one-cycle
   trigger and shows a filter value that moves on after each conversion.
   Assumes the block's clock and stage levels. */
`timescale 1ns/100ps
module adcts_front_model (
	input  wire        clk_sys,
	input  wire        fireReq,
	input  wire        convertActive,
	output reg         convTrigger,
	output reg  [15:0] filterValue
);
	reg convSeen_ff;
	// Start values so that no unknown reaches the block at time zero.
	initial begin
		convTrigger = 1'b0;
		filterValue = 16'h1234;
		convSeen_ff = 1'b0;
	end
	// A new value per sample keeps a stale read-back from passing.
	always @(posedge clk_sys) begin
		convTrigger <= fireReq;
		convSeen_ff <= convertActive;
		if (convSeen_ff && !convertActive)
			filterValue <= filterValue + 16'h0101;
	end
endmodule

/* File: verif/adcts_top_sva.sv */
/* Checker for the converter timing block, bound to its top module.
   Assumes one clock domain and the synchronous high reset. */
`timescale 1ns/100ps
module adcts_top_sva (
	input wire        clk_sys,
	input wire        srst,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        convTrigger,
	input wire        upperRefSupply,
	input wire        upperRefExternal,
	input wire        upperRefFixed,
	input wire        prechargeActive,
	input wire        acquireActive,
	input wire        convertActive,
	input wire        thresholdCheck
);
	// Everything here lives in the system clock domain.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
	uref_onehot_a: assert property ($onehot0({upperRefSupply, upperRefExternal, upperRefFixed}))
		else $error("upper reference not one-hot");
	stage_onehot_a: assert property ($onehot0({prechargeActive, acquireActive, convertActive}))
		else $error("two stages at once");
	pre_to_acq_a: assert property ($fell(prechargeActive) |-> acquireActive)
		else $error("precharge not followed by acquisition");
	acq_to_conv_a: assert property ($fell(acquireActive) |-> convertActive)
		else $error("acquisition not followed by conversion");
	conv_min_a: assert property ($rose(convertActive) |=> convertActive [*8])
		else $error("conversion stage too short");
	thr_pulse_a: assert property (thresholdCheck |=> !thresholdCheck) else $error("check not a pulse");
	thr_cause_a: assert property (thresholdCheck |-> $past(convTrigger) || $past(convTrigger, 2))
		else $error("check without trigger");
	// The main scenarios must really happen.
	cover property ($rose(prechargeActive));
	cover property ($fell(acquireActive));
	cover property (thresholdCheck);
endmodule
bind adcts_top adcts_top_sva chk_u (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .convTrigger(convTrigger),
	.upperRefSupply(upperRefSupply), .upperRefExternal(upperRefExternal), .upperRefFixed(upperRefFixed),
	.prechargeActive(prechargeActive), .acquireActive(acquireActive), .convertActive(convertActive),
	.thresholdCheck(thresholdCheck));

/* File: verif/adcts_top_tb_top.sv */
/* Self-checking bench: register table, decodes, stage codes and timing,
   tally per mode and a mid-run reset. Assumes the front-end model. */
`timescale 1ns/100ps
`include "adcts_consts.vh"
module adcts_top_tb_top;
	localparam [79:0]  IDX_TAB = {`ADCTS_IDX_TRIG_TALLY, `ADCTS_IDX_REPEAT_TGT, `ADCTS_IDX_PRECHARGE_LEN,
		`ADCTS_IDX_SAMPLE_LOAD, `ADCTS_IDX_SAMPLING_LEN, `ADCTS_IDX_POS_CHANNEL, `ADCTS_IDX_REF_SELECT,
		`ADCTS_IDX_CLK_DIVIDER};
	localparam [255:0] MASK_TAB = {32'hff, 32'hff, 32'h1fff, 32'h1f, 32'h1fff, 32'h3f, 32'h13, 32'h3f};
	reg         clk_sys = 1'b0;
	reg         srst = 1'b1;
	reg         cyc = 1'b0;
	reg         stb = 1'b0;
	reg         we = 1'b0;
	reg  [11:0] adr = 12'h000;
	reg  [31:0] wdat = 32'h0;
	reg         fireReq = 1'b0;
	reg  [31:0] v;
	wire [31:0] rdat;
	wire        ack, trig, lref, usup, uext, ufix, pre, acq, conv, thr;
	wire [15:0] fval;
	wire [5:0]  chan;
	wire [4:0]  load;
	integer     mismatches = 0;
	integer     comparisons = 0;
	integer     thrSeen = 0;
	integer     i;
	integer     n;
	// The 200 MHz system clock; threshold pulses are counted as they come.
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (thr === 1'b1) thrSeen = thrSeen + 1;
	// Byte lanes stay whole; narrow lanes are outside this bench.
	adcts_top dut_u (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.convTrigger(trig), .filterValue(fval), .lowerRefExternal(lref), .upperRefSupply(usup),
		.upperRefExternal(uext), .upperRefFixed(ufix), .channelSelect(chan), .sampleLoadPf(load),
		.prechargeActive(pre), .acquireActive(acq), .convertActive(conv), .thresholdCheck(thr));
	adcts_front_model front_u (.clk_sys(clk_sys), .fireReq(fireReq), .convertActive(conv),
		.convTrigger(trig), .filterValue(fval));
	// One classic cycle; read data is taken at the edge that sees ack.
	task wb(input [9:0] idx, input w, input [31:0] d);
		integer t;
		begin
			@(posedge clk_sys);
			{cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, d};
			t = 0;
			@(posedge clk_sys);
			while (ack !== 1'b1 && t < 50) begin
				@(posedge clk_sys);
				t = t + 1;
			end
			if (t == 50) mismatches = mismatches + 1;
			v = rdat;
			{cyc, stb} <= 2'b00;
		end
	endtask
	task cmpVal(input string name, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("wrong value %0s expected %h seen %h", name, e, g);
			end
		end
	endtask
	// First stages may lose up to one tick to phase, so they get a window.
	task cmpRange(input string name, input integer hi, input integer tol, input integer g);
		begin
			comparisons = comparisons + 1;
			if (g > hi || g < hi - tol) begin
				mismatches = mismatches + 1;
				$display("wrong value %0s expected %0d seen %0d", name, hi, g);
			end
		end
	endtask
	task rdChk(input [9:0] idx, input [31:0] e, input string name);
		begin
			wb(idx, 1'b0, 32'h0);
			cmpVal(name, e, v);
		end
	endtask
	task fire;
		begin
			@(posedge clk_sys);
			fireReq <= 1'b1;
			@(posedge clk_sys);
			fireReq <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
	endtask
	// Runs one conversion and counts the cycles spent in each stage.
	task convCase(input [5:0] d, input [12:0] p, input [12:0] q);
		integer pp, nq, dp, da, dc;
		begin
			pp = 2 * (d + 1);
			nq = (p == 0) ? q : ((q == 0) ? 8192 : q);
			wb(`ADCTS_IDX_CLK_DIVIDER, 1'b1, d);
			wb(`ADCTS_IDX_PRECHARGE_LEN, 1'b1, p);
			wb(`ADCTS_IDX_SAMPLING_LEN, 1'b1, q);
			wb(`ADCTS_IDX_CONTROL, 1'b1, 32'h1);
			dp = 0;
			da = 0;
			dc = 0;
			for (n = 0; n < 20000 && !(dc > 0 && conv !== 1'b1); n = n + 1) begin
				@(posedge clk_sys);
				dp = dp + (pre === 1'b1);
				da = da + (acq === 1'b1);
				dc = dc + (conv === 1'b1);
			end
			cmpRange("precharge", p * pp, (p != 0) ? pp : 0, dp);
			cmpRange("acquire", nq * pp, (p == 0 && nq != 0) ? pp : 0, da);
			cmpRange("convert", 14 * pp, (p == 0 && nq == 0) ? pp : 0, dc);
		end
	endtask
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, mismatches);
			if (mismatches == 0 && comparisons > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// Main sequence: reset, then each test in turn.
	initial begin
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		for (i = 0; i < 7; i = i + 1)
			rdChk(IDX_TAB[i*10 +: 10], 32'h0, "reset value");
		for (i = 0; i < 8; i = i + 1) begin
			wb(IDX_TAB[i*10 +: 10], 1'b1, 32'hffffffff);
			rdChk(IDX_TAB[i*10 +: 10], MASK_TAB[i*32 +: 32], "field mask");
		end
		wb(10'h000, 1'b1, 32'hffffffff);
		rdChk(10'h000, 32'h0, "unmapped");
		wb(`ADCTS_IDX_FILTER_OUT, 1'b1, 32'h0);
		rdChk(`ADCTS_IDX_FILTER_OUT, {16'h0, fval}, "filter read");
		$display("test registers done");
		for (i = 0; i < 8; i = i + 1) begin
			wb(`ADCTS_IDX_REF_SELECT, 1'b1, {27'h0, i[2], 2'b00, i[1:0]});
			wb(`ADCTS_IDX_POS_CHANNEL, 1'b1, i * 9);
			wb(`ADCTS_IDX_SAMPLE_LOAD, 1'b1, i * 4 + 3);
			repeat (2) @(posedge clk_sys);
			cmpVal("refs", {i[2], i[1:0] == 2'h0, i[1:0] == 2'h2, i[1:0] == 2'h3}, {lref, usup, uext, ufix});
			cmpVal("channel", i * 9, chan);
			cmpVal("load", i * 4 + 3, load);
		end
		$display("test decodes done");
		wb(`ADCTS_IDX_CLK_DIVIDER, 1'b1, 32'h3);
		wb(`ADCTS_IDX_PRECHARGE_LEN, 1'b1, 32'h2);
		wb(`ADCTS_IDX_SAMPLING_LEN, 1'b1, 32'h2);
		wb(`ADCTS_IDX_CONTROL, 1'b1, 32'h1);
		for (i = 1; i < 5; i = i + 1) begin
			for (n = 0; n < 500 && {conv, acq, pre} !== ((i == 4) ? 3'b000 : 3'b001 << (i - 1)); n = n + 1)
				@(posedge clk_sys);
			rdChk(`ADCTS_IDX_STATUS, i % 4, "stage code");
		end
		$display("test stage codes done");
		convCase(6'h00, 13'h0003, 13'h0002);
		convCase(6'h01, 13'h0002, 13'h0005);
		convCase(6'h02, 13'h0000, 13'h0004);
		convCase(6'h00, 13'h0000, 13'h0000);
		convCase(6'h00, 13'h0001, 13'h0000);
		$display("test stage timing done");
		for (i = 0; i < 5; i = i + 1) begin
			wb(`ADCTS_IDX_CONTROL, 1'b1, i << 4);
			rdChk(`ADCTS_IDX_CONTROL, i << 4, "mode");
			wb(`ADCTS_IDX_REPEAT_TGT, 1'b1, 32'h2);
			wb(`ADCTS_IDX_TRIG_TALLY, 1'b1, 32'h0);
			thrSeen = 0;
			repeat (2) fire;
			rdChk(`ADCTS_IDX_TRIG_TALLY, (i >= 2) ? 2 : 0, "tally");
			cmpVal("threshold", (i >= 2) ? 1 : 0, thrSeen);
		end
		$display("test tally done");
		wb(`ADCTS_IDX_TRIG_TALLY, 1'b1, 32'h5a);
		srst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		rdChk(`ADCTS_IDX_TRIG_TALLY, 32'h5a, "kept tally");
		rdChk(`ADCTS_IDX_REPEAT_TGT, 32'h0, "target reset");
		$display("test reset done");
		give_verdict;
	end
	// A hang is cut short well past the longest expected run.
	initial begin
		repeat (80000) @(posedge clk_sys);
		mismatches = mismatches + 1;
		give_verdict;
	end
endmodule
